// File: hw/nqs_defs.svh
// Register offsets, field positions, reset values and timing counts of the queue/protection bank
`ifndef NQS_DEFS_SVH
`define NQS_DEFS_SVH

`define NQS_OFF_STATUS      8'h04
`define NQS_OFF_CMD         8'h08
`define NQS_OFF_RESET       8'h0C
`define NQS_OFF_QBASE_LO    8'h10
`define NQS_OFF_QBASE_HI    8'h14
`define NQS_OFF_QUEUE_READ_OFFSET       8'h18
`define NQS_OFF_QUEUE_BUS_CONFIG     8'h1C
`define NQS_OFF_QUEUE_LENGTH       8'h20
`define NQS_OFF_ACTIVE_BUS_PROTECTION        8'h24

`define NQS_BIT_PRIV        0
`define NQS_BIT_SEC         1
`define NQS_ST_STATE        0
`define NQS_ST_RESET        3
`define NQS_ST_END          5
`define NQS_CMD_RUN         0

`define NQS_RST_WORD        32'h0000_0000
`define NQS_OFFSET_MAX      32'h0100_0000
`define NQS_QBASE_HI_W      16

// Cycles the soft reset sequence takes to clear the internal RAMs
`define NQS_RAM_WORDS       16
`define NQS_RAM_AW          4

`endif

// File: hw/nqs_pkg.sv
// Types shared by the queue and protection register bank
package nqs_pkg;

  typedef enum logic [2:0] {
    NQS_RESETTING = 3'b001,
    NQS_STOPPED   = 3'b010,
    NQS_RUNNING   = 3'b100
  } nqs_state_t;

  typedef enum logic [1:0] {
    NQS_P0_C0 = 2'h0,
    NQS_P0_C1 = 2'h1,
    NQS_P1_C2 = 2'h2,
    NQS_P1_C3 = 2'h3
  } nqs_qcfg_t;

endpackage : nqs_pkg

// File: hw/nqs_queue_regs.sv
// Command queue setup and bus protection registers with soft reset sequencing
//
// What this block does
// - Permitted reset write clears RAMs, stores value
// - Unpermitted reset write ignored entirely
// - Reset request bit 1: security, default secure
// - Reset request bit 0: privilege, default user
// - Low base gives address bits 31:0
// - High base gives address bits 47:32
// - Read offset reports current command position
// - Queue length gives next stream byte size
// - Queue config selects port and counter
// - Config code maps to port and counter
// - Active security bit drives AxPROT[1]
// - Hard reset: security from strap
// - Soft reset: security from request or forced
// - Active privilege bit drives AxPROT[0]
// - Hard reset: privilege from strap
// - Soft reset: privilege from request or forced
// - Base/length write while stopped clears end
// - During reset only status reads; writes dropped
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "nqs_defs.svh"

module nqs_queue_regs (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        poweronSecurityStrap,
  input  wire logic        poweronPrivilegeStrap,
  input  wire logic        resetPermitted,
  input  wire logic [1:0]  regPprot,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  output logic      [47:0] fetchAddr,
  output logic             fetchValid,
  input  wire logic        fetchReady,
  output logic             fetchPort,
  output logic      [1:0]  fetchCounter,
  output logic      [2:0]  axProt
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  nqs_pkg::nqs_state_t state_q;
  logic [31:0] resetReq_q;
  logic [31:0] qbaseLo_q;
  logic [`NQS_QBASE_HI_W-1:0] qbaseHi_q;
  logic [31:0] queue_read_offset_q;
  logic [31:0] queue_length_q;
  logic [1:0]  queue_bus_config_q;
  logic        activeSec_q;
  logic        activePriv_q;
  logic        endReached_q;
  logic        hardDone_q;
  logic [1:0]  softPprot_q;
  logic        softPending_q;
  logic [`NQS_RAM_AW-1:0] clrIdx_q;
  logic [31:0] ram [`NQS_RAM_WORDS];

  logic resetting;
  logic wrOk;
  logic softReq;
  logic clrLast;
  logic baseWrite;
  logic consume;

  assign resetting = (state_q == nqs_pkg::NQS_RESETTING);
  assign wrOk      = regWrite && !resetting;
  assign softReq   = wrOk && (regAddr == `NQS_OFF_RESET) && resetPermitted;
  assign clrLast   = (clrIdx_q == `NQS_RAM_AW'(`NQS_RAM_WORDS - 1));
  assign baseWrite = wrOk && (state_q == nqs_pkg::NQS_STOPPED) &&
                     (regAddr == `NQS_OFF_QBASE_LO || regAddr == `NQS_OFF_QBASE_HI ||
                      regAddr == `NQS_OFF_QUEUE_LENGTH);
  assign consume   = fetchValid && fetchReady;

  // ----------------------------------------------------------------
  // Reset sequencer: RAM clear walks one word per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= nqs_pkg::NQS_RESETTING;
      clrIdx_q <= '0;
    end else begin
      unique case (state_q)
        nqs_pkg::NQS_RESETTING: begin
          clrIdx_q <= clrIdx_q + `NQS_RAM_AW'(1);
          if (clrLast) begin
            state_q <= nqs_pkg::NQS_STOPPED;
          end
        end
        nqs_pkg::NQS_STOPPED: begin
          clrIdx_q <= '0;
          if (softReq) begin
            state_q <= nqs_pkg::NQS_RESETTING;
          end else if (wrOk && regAddr == `NQS_OFF_CMD && regWdata[`NQS_CMD_RUN]) begin
            state_q <= nqs_pkg::NQS_RUNNING;
          end
        end
        nqs_pkg::NQS_RUNNING: begin
          clrIdx_q <= '0;
          if (softReq) begin
            state_q <= nqs_pkg::NQS_RESETTING;
          end else if (queue_read_offset_q >= queue_length_q) begin
            state_q <= nqs_pkg::NQS_STOPPED;
          end
        end
        default: begin
          state_q <= nqs_pkg::NQS_RESETTING;
        end
      endcase
    end
  end

  // Internal RAM has no reset; it is wiped by the sequencer instead
  always_ff @(posedge mclk) begin
    if (resetting) begin
      ram[clrIdx_q] <= '0;
    end else if (consume) begin
      ram[queue_read_offset_q[`NQS_RAM_AW+1:2]] <= regWdata;
    end
  end

  // ----------------------------------------------------------------
  // Reset request register and captured requester protection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resetReq_q    <= `NQS_RST_WORD;
      softPprot_q   <= '0;
      softPending_q <= 1'b0;
    end else if (softReq) begin
      resetReq_q    <= {30'h0000_0000, regWdata[`NQS_BIT_SEC], regWdata[`NQS_BIT_PRIV]};
      softPprot_q   <= regPprot;
      softPending_q <= 1'b1;
    end else if (resetting && clrLast) begin
      softPending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Active protection: strap after hard reset, request or forced value after soft
  // ----------------------------------------------------------------
  // Straps are caught on the first clocked edge after release, never
  // in the asynchronous branch.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      activeSec_q  <= 1'b0;
      activePriv_q <= 1'b0;
      hardDone_q   <= 1'b0;
    end else if (!hardDone_q) begin
      activeSec_q  <= poweronSecurityStrap;
      activePriv_q <= poweronPrivilegeStrap;
      hardDone_q   <= 1'b1;
    end else if (softPending_q && resetting && clrLast) begin
      activeSec_q  <= softPprot_q[1] ? 1'b1 : resetReq_q[`NQS_BIT_SEC];
      activePriv_q <= softPprot_q[0] ? resetReq_q[`NQS_BIT_PRIV] : 1'b0;
    end
  end

  // Instruction/data bit stays 0; data-side accesses only
  assign axProt = {1'b0, activeSec_q, activePriv_q};

  // ----------------------------------------------------------------
  // Queue setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      qbaseLo_q <= '0;
      qbaseHi_q <= '0;
      queue_length_q   <= '0;
      queue_bus_config_q <= '0;
    end else if (wrOk) begin
      unique case (regAddr)
        `NQS_OFF_QBASE_LO: qbaseLo_q <= {regWdata[31:2], 2'b00};
        `NQS_OFF_QBASE_HI: qbaseHi_q <= regWdata[`NQS_QBASE_HI_W-1:0];
        `NQS_OFF_QUEUE_LENGTH:    queue_length_q   <= (regWdata > `NQS_OFFSET_MAX) ?
                                        `NQS_OFFSET_MAX : {regWdata[31:2], 2'b00};
        `NQS_OFF_QUEUE_BUS_CONFIG:  queue_bus_config_q <= regWdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fetch engine and read offset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      queue_read_offset_q <= '0;
    end else if (resetting || (state_q == nqs_pkg::NQS_STOPPED &&
                               wrOk && regAddr == `NQS_OFF_CMD && regWdata[`NQS_CMD_RUN])) begin
      queue_read_offset_q <= '0;
    end else if (consume) begin
      queue_read_offset_q <= queue_read_offset_q + 32'h0000_0004;
    end
  end

  assign fetchValid = (state_q == nqs_pkg::NQS_RUNNING) && (queue_read_offset_q < queue_length_q);
  assign fetchAddr  = {qbaseHi_q, qbaseLo_q} + {16'h0000, queue_read_offset_q};

  // Port follows the high code bit; counter is the code itself
  assign fetchPort    = queue_bus_config_q[1];
  assign fetchCounter = queue_bus_config_q;

  // End flag: reaching the end wins over a same-cycle clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      endReached_q <= 1'b0;
    end else if (state_q == nqs_pkg::NQS_RUNNING && queue_read_offset_q >= queue_length_q) begin
      endReached_q <= 1'b1;
    end else if (baseWrite || resetting) begin
      endReached_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= '0;
    end else if (!regRead) begin
      regRdata <= '0;
    end else if (resetting) begin
      regRdata <= (regAddr == `NQS_OFF_STATUS) ? 32'h0000_0008 : 32'h0000_0000;
    end else begin
      unique case (regAddr)
        `NQS_OFF_STATUS:   regRdata <= {26'h0, endReached_q, 4'h0,
                                        state_q == nqs_pkg::NQS_RUNNING};
        `NQS_OFF_RESET:    regRdata <= resetReq_q;
        `NQS_OFF_QBASE_LO: regRdata <= qbaseLo_q;
        `NQS_OFF_QBASE_HI: regRdata <= {16'h0000, qbaseHi_q};
        `NQS_OFF_QUEUE_READ_OFFSET:    regRdata <= queue_read_offset_q;
        `NQS_OFF_QUEUE_BUS_CONFIG:  regRdata <= {30'h0, queue_bus_config_q};
        `NQS_OFF_QUEUE_LENGTH:    regRdata <= queue_length_q;
        `NQS_OFF_ACTIVE_BUS_PROTECTION:     regRdata <= {30'h0, activeSec_q, activePriv_q};
        default:           regRdata <= '0;
      endcase
    end
  end

endmodule : nqs_queue_regs
`default_nettype wire

// File: sim/nqs_queue_regs_asserts.sv
// Port checker for the queue and protection register bank
`timescale 1ns/1ps
`default_nettype none
`include "nqs_defs.svh"
module nqs_queue_regs_chk (
  input wire logic        mclk, reset_n, poweronSecurityStrap, poweronPrivilegeStrap,
  input wire logic        resetPermitted, regWrite, regRead, fetchValid, fetchReady,
  input wire logic        fetchPort,
  input wire logic [1:0]  regPprot, fetchCounter,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata, regRdata,
  input wire logic [47:0] fetchAddr,
  input wire logic [2:0]  axProt
);
  // ----------------------------------------
  // Reset tracking and properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic rstWr = regWrite && regAddr == `NQS_OFF_RESET && resetPermitted;
  logic [4:0] busyCnt_q;
  // Padded past the real clear length so a slow clear never trips a check
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busyCnt_q <= 5'h14;
    else if (rstWr && busyCnt_q == 5'h0) busyCnt_q <= 5'h14;
    else if (busyCnt_q != 5'h0) busyCnt_q <= busyCnt_q - 5'h1;
  end
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside its answer cycle");
  a_reset_blank: assert property (regRead && regAddr != `NQS_OFF_STATUS && busyCnt_q > 5'h6
    |=> regRdata == 32'h0) else $error("register readable during reset");
  a_active_bus_protection_upper: assert property (axProt[2] == 1'h0) else $error("bus active_bus_protection bit 2 set");
  a_port_decode: assert property (fetchPort == fetchCounter[1])
    else $error("port does not follow counter code");
  a_cfg_cause: assert property ($changed(fetchCounter) |->
    $past(regWrite && regAddr == `NQS_OFF_QUEUE_BUS_CONFIG) || busyCnt_q != 5'h0)
    else $error("config changed without a write");
  a_fetch_step: assert property (fetchValid && fetchReady && !regWrite
    |=> fetchAddr == $past(fetchAddr) + 48'h4) else $error("fetch address step wrong");
  a_addr_align: assert property (fetchAddr[1:0] == 2'h0) else $error("fetch unaligned");
  a_active_bus_protection_hold: assert property (rstWr && busyCnt_q == 5'h0 |=> $stable(axProt)[*8])
    else $error("bus active_bus_protection moved early in soft reset");
  a_active_bus_protection_strap: assert property ($rose(reset_n) |=> axProt[1:0] ==
    {$past(poweronSecurityStrap), $past(poweronPrivilegeStrap)})
    else $error("bus active_bus_protection not loaded from straps");
endmodule : nqs_queue_regs_chk

bind nqs_queue_regs nqs_queue_regs_chk u_chk (.mclk, .reset_n, .poweronSecurityStrap,
  .poweronPrivilegeStrap, .resetPermitted, .regWrite, .regRead, .fetchValid, .fetchReady,
  .fetchPort, .regPprot, .fetchCounter, .regAddr, .regWdata, .regRdata, .fetchAddr, .axProt);
`default_nettype wire

// File: sim/nqs_fetch_mem.sv
// Command memory stand-in that accepts fetches promptly or with random stalls
`timescale 1ns/1ps
`default_nettype none
module nqs_fetch_mem (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic slowMode,
  output logic      fetchReady
);
  // Ready is a willingness flag only, so toggling it with no fetch pending is harmless
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) fetchReady <= 1'h0;
    else fetchReady <= slowMode ? 1'($urandom) : 1'h1;
  end
endmodule : nqs_fetch_mem
`default_nettype wire

// File: sim/tb_npu_queue_and_security_regs.sv
// Self-checking bench for the queue and protection register bank
`timescale 1ns/1ps
`default_nettype none
`include "nqs_defs.svh"
module tb_npu_queue_and_security_regs;
  logic mclk = 0, reset_n = 0, secStrap, privStrap, resetPermitted = 0, slowMode = 0;
  logic regWrite = 0, regRead = 0, fetchValid, fetchReady, fetchPort;
  logic [1:0] regPprot = 0, fetchCounter, d, p;
  logic [7:0] regAddr = 0;
  logic [31:0] regWdata = 0, regRdata, rdv, lo, hi;
  logic [47:0] fetchAddr, base;
  // Behavioural model: register image per offset and queue of expected fetches
  int unsigned mdl[int];
  logic [47:0] fq[$];
  logic [2:0] axProt;
  int err_total = 0, n_compared = 0, off;
  logic [7:0] a0[7] = '{`NQS_OFF_RESET, `NQS_OFF_QBASE_LO, `NQS_OFF_QBASE_HI,
    `NQS_OFF_QUEUE_READ_OFFSET, `NQS_OFF_QUEUE_BUS_CONFIG, `NQS_OFF_QUEUE_LENGTH, 8'hFC};
  nqs_queue_regs u_dut (.mclk, .reset_n, .poweronSecurityStrap(secStrap),
    .poweronPrivilegeStrap(privStrap), .resetPermitted, .regPprot, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .fetchAddr, .fetchValid, .fetchReady, .fetchPort,
    .fetchCounter, .axProt);
  nqs_fetch_mem u_mem (.mclk, .reset_n, .slowMode, .fetchReady);
  initial forever #5 mclk = ~mclk;
  // ----------------------------------------
  // Bus tasks and checking
  // ----------------------------------------
  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge mclk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= v;
    @(posedge mclk);
    regWrite <= 1'h0;
    if (a == `NQS_OFF_QBASE_LO) mdl[a] = v & 32'hFFFF_FFFC;
    if (a == `NQS_OFF_QBASE_HI) mdl[a] = v & 32'h0000_FFFF;
    if (a == `NQS_OFF_QUEUE_LENGTH) mdl[a] = (v > 32'h0100_0000) ? 32'h0100_0000 : v & 32'hFFFF_FFFC;
    if (a == `NQS_OFF_QUEUE_BUS_CONFIG) mdl[a] = v & 32'h0000_0003;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge mclk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'h0;
    #1 rdv = regRdata;
  endtask : rd
  // Polls the reset flag, bounded so a stuck reset shows up as mismatches
  task automatic settle();
    for (int i = 0; i < 40; i++) begin
      rd(`NQS_OFF_STATUS);
      if (rdv[`NQS_ST_RESET] === 1'h0) break;
    end
  endtask : settle
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(87324));
    secStrap <= 1'($urandom);
    privStrap <= 1'($urandom);
    repeat (3) @(posedge mclk);
    reset_n <= 1'h1;
    settle();
    foreach (a0[i]) begin
      rd(a0[i]);
      chk("reset value", rdv, 48'h0);
    end
    rd(`NQS_OFF_ACTIVE_BUS_PROTECTION);
    chk("strap level", rdv, {secStrap, privStrap});
    chk("bus active_bus_protection", axProt, {secStrap, privStrap});
    $display("test reset values done");
    for (int c = 0; c < 4; c++) begin
      wr(`NQS_OFF_QUEUE_BUS_CONFIG, ($urandom & 32'hFFFF_FFFC) | 32'(c));
      rd(`NQS_OFF_QUEUE_BUS_CONFIG);
      chk("config", rdv, 48'(c));
      chk("port counter", {fetchPort, fetchCounter}, {c >= 2, c[1:0]});
    end
    $display("test config done");
    lo = $urandom;
    hi = $urandom;
    wr(`NQS_OFF_QBASE_LO, lo);
    wr(`NQS_OFF_QBASE_HI, hi);
    wr(`NQS_OFF_QUEUE_LENGTH, 32'hFFFF_FFFF);
    rd(`NQS_OFF_QBASE_LO);
    chk("base low", rdv, mdl[`NQS_OFF_QBASE_LO]);
    rd(`NQS_OFF_QBASE_HI);
    chk("base high", rdv, mdl[`NQS_OFF_QBASE_HI]);
    rd(`NQS_OFF_QUEUE_LENGTH);
    chk("length cap", rdv, mdl[`NQS_OFF_QUEUE_LENGTH]);
    wr(`NQS_OFF_QUEUE_LENGTH, 32'h0000_0010);
    slowMode <= 1'h1;
    wr(`NQS_OFF_CMD, 32'h0000_0001);
    base = (48'(mdl[`NQS_OFF_QBASE_HI]) << 32) | 48'(mdl[`NQS_OFF_QBASE_LO]);
    for (int j = 0; j < 16; j += 4) fq.push_back(base + 48'(j));
    off = 0;
    for (int i = 0; i < 200 && off < 16; i++) begin
      @(negedge mclk);
      if (fetchValid === 1'h1 && fetchReady === 1'h1) begin
        chk("fetch addr", fetchAddr, fq.pop_front());
        off += 4;
      end
    end
    rd(`NQS_OFF_QUEUE_READ_OFFSET);
    chk("read offset", rdv, 32'h0000_0010);
    rd(`NQS_OFF_STATUS);
    chk("end flag", rdv[`NQS_ST_END], 1'h1);
    chk("stream stop", fetchValid, 1'h0);
    wr(`NQS_OFF_QUEUE_LENGTH, 32'h0000_0008);
    rd(`NQS_OFF_STATUS);
    chk("end cleared", rdv[`NQS_ST_END], 1'h0);
    $display("test fetch done");
    for (int k = 0; k < 16; k++) begin
      p = k[3:2];
      d = k[1:0] & {1'h1, p[0]};
      @(posedge mclk);
      regPprot <= p;
      resetPermitted <= 1'h1;
      wr(`NQS_OFF_RESET, 32'(d));
      rd(`NQS_OFF_QBASE_LO);
      chk("blank read", rdv, 48'h0);
      settle();
      rd(`NQS_OFF_RESET);
      chk("reset request", rdv, d);
      rd(`NQS_OFF_ACTIVE_BUS_PROTECTION);
      chk("active level", rdv, {p[1] | d[1], d[0] & p[0]});
      chk("bus active_bus_protection", axProt, {1'h0, p[1] | d[1], d[0] & p[0]});
    end
    $display("test soft reset done");
    @(posedge mclk);
    resetPermitted <= 1'h0;
    wr(`NQS_OFF_RESET, 32'h0000_0000);
    rd(`NQS_OFF_STATUS);
    chk("no reset", rdv[`NQS_ST_RESET], 1'h0);
    rd(`NQS_OFF_RESET);
    chk("ignored reset", rdv, 32'h0000_0003);
    $display("test refused reset done");
    print_verdict();
  end
endmodule : tb_npu_queue_and_security_regs
`default_nettype wire
